// ---- core/gbp_defs.vh ----
// Constants for the grouped byte port I/O block
`ifndef GBP_DEFS_VH
`define GBP_DEFS_VH
// Register byte offsets
`define GBP_OFF_CMD      12'h000
`define GBP_OFF_STATUS   12'h004
`define GBP_OFF_POLARITY 12'h008
`define GBP_OFF_HSCFG    12'h00C
`define GBP_OFF_WDATA0   12'h010
`define GBP_OFF_WDATA1   12'h014
`define GBP_OFF_WDATA2   12'h018
`define GBP_OFF_RDATA0   12'h020
`define GBP_OFF_RDATA1   12'h024
`define GBP_OFF_RDATA2   12'h028
// Command register fields
`define GBP_CMD_GO_BIT   0
`define GBP_CMD_RD_BIT   1
`define GBP_CMD_BITOP    2
`define GBP_CMD_BITVAL   3
`define GBP_CMD_WID_LSB  4
`define GBP_CMD_PORT_LSB 8
`define GBP_CMD_BIT_LSB  16
// Group widths
`define GBP_W_BYTE 3'd0
`define GBP_W_WORD 3'd1
`define GBP_W_QUAD 3'd2
`define GBP_W_OCT  3'd3
`define GBP_W_ALL  3'd4
// Handshake modes
`define GBP_HS_NONE   2'd0
`define GBP_HS_STROBE 2'd1
`define GBP_HS_FLAG   2'd2
// Status bits
`define GBP_ST_BUSY 0
`define GBP_ST_ERR  1
`define GBP_ST_RDV  2
// Timing
`define GBP_PORT_GAP_NS 10
`define GBP_CLK_NS      5
// Port gap rounded up to whole clocks, sized to the gap counter
`define GBP_PORT_GAP_CYC 4'd2
`endif

// ---- core/gbp_skid_buf.v ----
// Two-entry valid/ready buffer for read results
`timescale 1ns/1ps
module gbp_skid_buf #(
  parameter W = 96
) (
  input  wire         i_sys_clk,
  input  wire         i_rst_n,
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);
  reg [W-1:0] mem_reg [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  cnt_reg;
  wire        push = i_valid && (cnt_reg != 2'd2);
  wire        pop  = (cnt_reg != 2'd0) && i_ready;

  assign o_ready = (cnt_reg != 2'd2);
  assign o_valid = (cnt_reg != 2'd0);
  assign o_data  = mem_reg[rd_ptr_reg];

  // Pointers and occupancy
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'd0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= i_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'd1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'd1;
    end
  end
endmodule // gbp_skid_buf

// ---- core/gbp_port_io.v ----
// Twelve byte ports with grouping, polarity and handshake over AHB-Lite
`timescale 1ns/1ps
`include "gbp_defs.vh"

// Summary of operation
// - Twelve byte ports, numbered zero to eleven.
// - Bit write takes only zero or one, completes through output handshake.
// - Bit index 0..7 per port, 0..95 across combined ports.
// - Bit k drives line k; bit seven is MSB.
// - True-high polarity drives one high; inverted polarity drives complement.
// - Word groups two ports; quad groups four ports.
// - Eight- and twelve-port groups; each group is one transfer.
// - Base ports: word even to ten, quad 0/4/8, larger only 0.
// - Unnamed port means port zero, any width.
// - Grouped read runs input handshake, then returns combined lines.
// - One handshake mode and delay govern the whole group.
// - Control lines switch lowest to highest port with small gaps.
// - Any flag change in group advances handshake for all ports.
// - Strobe: data, wait, assert, wait, deassert; flag unused.
// - No handshake: move immediately; outputs stay outputs.
module gbp_port_io #(
  parameter NPORT = 12,
  parameter DW    = 16
) (
  input  wire             i_sys_clk,
  input  wire             i_rst_n,
  input  wire             i_hsel,
  input  wire [11:0]      i_haddr,
  input  wire [1:0]       i_htrans,
  input  wire             i_hwrite,
  input  wire [2:0]       i_hsize,
  input  wire [31:0]      i_hwdata,
  input  wire             i_hready,
  output reg  [31:0]      o_hrdata,
  output reg              o_hreadyout,
  output reg              o_hresp,
  input  wire [95:0]      i_port_data_line,
  output reg  [95:0]      o_port_data_line,
  output reg  [95:0]      o_port_data_oe,
  output reg  [11:0]      o_control_strobe_line,
  input  wire [11:0]      i_peripheral_flag_line
);
  localparam S_IDLE = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_ASRT = 3'd2;
  localparam S_HOLD = 3'd3;
  localparam S_DEAS = 3'd4;
  localparam S_FLAG = 3'd5;
  localparam S_DONE = 3'd6;
  localparam [3:0] GAP = `GBP_PORT_GAP_CYC;

  reg [2:0]    state_reg;
  reg [95:0]   out_reg;       // Logical data, before polarity
  reg [95:0]   dir_reg;
  reg [11:0]   pol_reg;       // One inverts the port
  reg [1:0]    mode_reg;
  reg [DW-1:0] delay_reg;
  reg [DW-1:0] cnt_reg;
  reg [3:0]    gap_reg;
  reg [3:0]    cur_reg;       // Port whose control line switches next
  reg [3:0]    base_reg;
  reg [3:0]    last_reg;
  reg          rd_reg;
  reg          err_reg;
  reg          rdv_reg;
  reg [95:0]   wdata_reg;
  reg [11:0]   flag_q_reg;
  reg          ap_valid_reg;
  reg          ap_write_reg;
  reg [11:0]   ap_addr_reg;
  reg          rb_pop_reg;

  // Command decode of the incoming word
  wire [2:0] c_wid  = i_hwdata[`GBP_CMD_WID_LSB +: 3];
  wire [3:0] c_port = i_hwdata[`GBP_CMD_PORT_LSB +: 4];
  wire [6:0] c_bit  = i_hwdata[`GBP_CMD_BIT_LSB +: 7];
  reg  [3:0] c_span;
  reg        c_ok;

  // Group extent and legal base ports
  always @* begin
    c_span = 4'd0;
    c_ok   = 1'b0;
    case (c_wid)
      `GBP_W_BYTE: begin
        c_span = 4'd0;
        c_ok   = (c_port < NPORT);
      end
      `GBP_W_WORD: begin
        c_span = 4'd1;
        c_ok   = !c_port[0] && (c_port <= 4'd10);
      end
      `GBP_W_QUAD: begin
        c_span = 4'd3;
        c_ok   = (c_port[1:0] == 2'd0) && (c_port <= 4'd8);
      end
      `GBP_W_OCT: begin
        c_span = 4'd7;
        c_ok   = (c_port == 4'd0);
      end
      `GBP_W_ALL: begin
        c_span = 4'd11;
        c_ok   = (c_port == 4'd0);
      end
      default: begin
        c_span = 4'd0;
        c_ok   = 1'b0;
      end
    endcase
  end

  // Bit operation checks; index is relative to the group base
  wire       bit_ok   = (c_bit <= {c_span, 3'b111});
  wire [6:0] abs_bit  = {c_port, 3'b000} + c_bit;
  wire [95:0] grp_mask;
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_mask
      assign grp_mask[g*8 +: 8] = {8{(g >= c_port) && (g <= c_port + c_span)}};
    end
  endgenerate

  // Read-result buffer between the handshake engine and the bus
  wire        rb_in_ready;
  wire        rb_valid;
  wire [95:0] rb_data;
  reg  [95:0] cap_reg;
  reg         cap_vld_reg;
  gbp_skid_buf #(.W(96)) u_rbuf (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_valid   (cap_vld_reg),
    .o_ready   (rb_in_ready),
    .i_data    (cap_reg),
    .o_valid   (rb_valid),
    .i_ready   (rb_pop_reg),
    .o_data    (rb_data)
  );

  wire [95:0] pol_exp;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_pol
      assign pol_exp[g*8 +: 8] = {8{pol_reg[g]}};
    end
  endgenerate

  // Ports of the running transfer, held for its whole length
  wire [11:0] grp_sel;
  wire [95:0] grp_mask_q;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_sel
      assign grp_sel[g]           = (g >= base_reg) && (g <= last_reg);
      assign grp_mask_q[g*8 +: 8] = {8{grp_sel[g]}};
    end
  endgenerate

  // Any flag edge inside the group starts releasing every port, lowest first, with gaps
  wire flag_chg = |((i_peripheral_flag_line ^ flag_q_reg) & grp_sel);

  wire start = ap_valid_reg && ap_write_reg && (ap_addr_reg == `GBP_OFF_CMD)
               && i_hwdata[`GBP_CMD_GO_BIT] && (state_reg == S_IDLE);
  wire bit_cmd = i_hwdata[`GBP_CMD_BITOP];
  wire cmd_ok  = c_ok && (!bit_cmd || (bit_ok && !i_hwdata[`GBP_CMD_RD_BIT]));

  // Handshake setting as read back; the delay may be narrower than its field
  reg [31:0] hscfg_rd;
  always @* begin
    hscfg_rd           = 32'h0000_0000;
    hscfg_rd[1:0]      = mode_reg;
    hscfg_rd[16 +: DW] = delay_reg;
  end

  // Bus slave, handshake engine and pin drivers
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg             <= S_IDLE;
      out_reg               <= 96'd0;
      dir_reg               <= 96'd0;
      pol_reg               <= 12'd0;
      mode_reg              <= `GBP_HS_NONE;
      delay_reg             <= {DW{1'b0}};
      cnt_reg               <= {DW{1'b0}};
      gap_reg               <= 4'd0;
      cur_reg               <= 4'd0;
      base_reg              <= 4'd0;
      last_reg              <= 4'd0;
      rd_reg                <= 1'b0;
      err_reg               <= 1'b0;
      rdv_reg               <= 1'b0;
      wdata_reg             <= 96'd0;
      flag_q_reg            <= 12'd0;
      ap_valid_reg          <= 1'b0;
      ap_write_reg          <= 1'b0;
      ap_addr_reg           <= 12'd0;
      rb_pop_reg            <= 1'b0;
      cap_reg               <= 96'd0;
      cap_vld_reg           <= 1'b0;
      o_hrdata              <= 32'd0;
      o_hreadyout           <= 1'b1;
      o_hresp               <= 1'b0;
      o_port_data_line      <= 96'd0;
      o_port_data_oe        <= 96'd0;
      o_control_strobe_line <= 12'd0;
    end else begin
      flag_q_reg  <= i_peripheral_flag_line;
      rb_pop_reg  <= 1'b0;
      cap_vld_reg <= cap_vld_reg && !rb_in_ready;
      // An entry popped in this cycle must not re-arm the flag
      if (rb_valid && !rb_pop_reg) rdv_reg <= 1'b1;
      // Address phase capture; zero wait states
      ap_valid_reg <= i_hsel && i_htrans[1] && i_hready;
      ap_write_reg <= i_hwrite;
      ap_addr_reg  <= i_haddr;
      if (ap_valid_reg && ap_write_reg) begin
        case (ap_addr_reg)
          `GBP_OFF_POLARITY: pol_reg <= i_hwdata[11:0];
          `GBP_OFF_HSCFG: begin
            mode_reg  <= i_hwdata[1:0];
            delay_reg <= i_hwdata[16 +: DW];
          end
          `GBP_OFF_WDATA0: wdata_reg[31:0]  <= i_hwdata;
          `GBP_OFF_WDATA1: wdata_reg[63:32] <= i_hwdata;
          `GBP_OFF_WDATA2: wdata_reg[95:64] <= i_hwdata;
          default: ;
        endcase
      end
      // Read data chosen in this address phase, for the data phase
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
        case (i_haddr)
          `GBP_OFF_STATUS:   o_hrdata <= {29'd0, rdv_reg, err_reg, state_reg != S_IDLE};
          `GBP_OFF_POLARITY: o_hrdata <= {20'd0, pol_reg};
          `GBP_OFF_HSCFG:    o_hrdata <= hscfg_rd;
          `GBP_OFF_RDATA0:   o_hrdata <= rb_data[31:0];
          `GBP_OFF_RDATA1:   o_hrdata <= rb_data[63:32];
          `GBP_OFF_RDATA2: begin
            o_hrdata   <= rb_data[95:64];
            rb_pop_reg <= rb_valid;                         // Last word frees the entry
            rdv_reg    <= 1'b0;
          end
          default:           o_hrdata <= 32'd0;
        endcase
      end
      case (state_reg)
        S_IDLE: if (start) begin
          err_reg <= !cmd_ok;
          if (cmd_ok) begin
            base_reg <= c_port;
            last_reg <= c_port + c_span;
            rd_reg   <= i_hwdata[`GBP_CMD_RD_BIT];
            cur_reg  <= c_port;
            cnt_reg  <= delay_reg;
            if (bit_cmd) begin
              out_reg[abs_bit] <= i_hwdata[`GBP_CMD_BITVAL];
              dir_reg[abs_bit] <= 1'b1;
            end else if (!i_hwdata[`GBP_CMD_RD_BIT]) begin
              out_reg <= (out_reg & ~grp_mask) | (wdata_reg & grp_mask);
              dir_reg <= dir_reg | grp_mask;
            end else
              dir_reg <= dir_reg & ~grp_mask;
            if (mode_reg == `GBP_HS_NONE) state_reg <= S_DONE;
            else state_reg <= S_WAIT;
          end
        end
        S_WAIT: if (cnt_reg == {DW{1'b0}}) begin
          state_reg <= S_ASRT;
          gap_reg   <= 4'd0;
        end else cnt_reg <= cnt_reg - 1'b1;
        S_ASRT: if (gap_reg == 4'd0) begin
          o_control_strobe_line[cur_reg] <= 1'b1;
          gap_reg <= GAP;
          if (cur_reg == last_reg) begin
            cur_reg   <= base_reg;
            cnt_reg   <= delay_reg;
            state_reg <= (mode_reg == `GBP_HS_STROBE) ? S_HOLD : S_FLAG;
          end else cur_reg <= cur_reg + 4'd1;
        end else gap_reg <= gap_reg - 4'd1;
        S_FLAG: if (flag_chg) begin
          state_reg <= S_DEAS;
          gap_reg   <= 4'd0;
        end
        S_HOLD: if (cnt_reg == {DW{1'b0}}) begin
          state_reg <= S_DEAS;
          gap_reg   <= 4'd0;
        end else cnt_reg <= cnt_reg - 1'b1;
        S_DEAS: if (gap_reg == 4'd0) begin
          o_control_strobe_line[cur_reg] <= 1'b0;
          gap_reg <= GAP;
          if (cur_reg == last_reg) state_reg <= S_DONE;
          else cur_reg <= cur_reg + 4'd1;
        end else gap_reg <= gap_reg - 4'd1;
        S_DONE: if (!rd_reg) state_reg <= S_IDLE;
        else if (!cap_vld_reg) begin
          // Right-justify the group so its base port lands at bit zero
          cap_reg     <= ((i_port_data_line ^ pol_exp) & grp_mask_q) >> {base_reg, 3'b000};
          cap_vld_reg <= 1'b1;
          state_reg   <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      o_port_data_line <= out_reg ^ pol_exp;
      o_port_data_oe   <= dir_reg;
    end
  end
endmodule // gbp_port_io

// ---- verif/gbp_port_io_chk.sv ----
// Port-level assertions for the grouped byte port block
`timescale 1ns/1ps
module gbp_port_io_chk #(
  parameter NPORT = 12,
  parameter DW    = 16
) (
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_hsel,
  input wire [11:0] i_haddr,
  input wire [1:0]  i_htrans,
  input wire        i_hwrite,
  input wire        i_hready,
  input wire [31:0] o_hrdata,
  input wire        o_hreadyout,
  input wire        o_hresp,
  input wire [95:0] o_port_data_line,
  input wire [95:0] o_port_data_oe,
  input wire [11:0] o_control_strobe_line
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire [11:0] ctl     = o_control_strobe_line;
  wire        addr_ok = i_hsel && i_htrans[1] && i_hready;
  wire        wr_out  = addr_ok && i_hwrite && (i_haddr == 12'h000 || i_haddr == 12'h008);
  reg  [3:0]  since_wr;
  // Handshake on for two samples in a row
  sequence s_hs_on;
    (|ctl) [*2];
  endsequence
  // Read address phase accepted
  sequence s_rd_addr;
    addr_ok && !i_hwrite;
  endsequence
  // Age of the last command or polarity write, saturating
  always @(posedge i_sys_clk) begin
    if (!i_rst_n || wr_out) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end
  AST_BUS_OK: assert property (o_hreadyout && !o_hresp) else $error("bus answer not ready or not okay");
  AST_RD_CAUSE: assert property ($changed(o_hrdata) |-> $past(addr_ok && !i_hwrite))
    else $error("read data moved without a read");
  AST_DATA_STEADY: assert property (s_hs_on |-> $stable(o_port_data_line))
    else $error("data moved during handshake");
  AST_DATA_CAUSE: assert property ($changed(o_port_data_line) |-> since_wr <= 4'h6)
    else $error("data moved without a write");
  AST_OE_KEEP: assert property ($changed(o_port_data_oe) |-> since_wr <= 4'h6)
    else $error("direction moved without a command");
  AST_RESET_CLEAR: assert property ($rose(i_rst_n) |-> ctl == 12'h000 && o_port_data_oe == 96'h0)
    else $error("lines active out of reset");
  genvar k;
  for (k = 0; k < 11; k = k + 1) begin : g_ord
    AST_RISE_ORDER: assert property ($rose(ctl[k]) |-> !ctl[k+1])
      else $error("higher control line rose first");
    AST_FALL_ORDER: assert property ($fell(ctl[k+1]) |-> !ctl[k])
      else $error("lower control line fell last");
    AST_RISE_GAP: assert property ($rose(ctl[k+1]) && ctl[k] |-> $past(ctl[k], 2))
      else $error("control lines too close");
  end
endmodule // gbp_port_io_chk
bind gbp_port_io gbp_port_io_chk #(.NPORT(NPORT), .DW(DW)) i_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_port_data_line(o_port_data_line),
  .o_port_data_oe(o_port_data_oe), .o_control_strobe_line(o_control_strobe_line));

// ---- verif/gbp_periph_model.sv ----
// Behavioural peripheral: input levels and flag answers
`timescale 1ns/1ps
module gbp_periph_model #(
  parameter [95:0] PAT = 96'h0000_0000_0000_0000_0000_0000
) (
  input  wire        i_sys_clk,
  input  wire [11:0] i_ctl,
  output reg  [11:0] o_flag,
  output wire [95:0] o_drive,
  output reg  [7:0]  o_rises
);
  reg [11:0] ctl_q = 12'h000;
  reg [3:0]  still = 4'h0;
  integer    k;
  integer    hi;
  initial o_flag = 12'h000;
  initial o_rises = 8'h00;
  // Fixed levels on lines the block leaves undriven
  assign o_drive = PAT;
  // Answer once control lines settle, on the top raised port only
  always @(posedge i_sys_clk) begin
    ctl_q <= i_ctl;
    hi = 0;
    for (k = 0; k < 12; k = k + 1) begin
      if (i_ctl[k]) hi = k;
      if (i_ctl[k] && !ctl_q[k]) o_rises <= o_rises + 8'h01; // Counts one rise per cycle
    end
    if (i_ctl != ctl_q || i_ctl == 12'h000) still <= 4'h0;
    else if (still != 4'hf) still <= still + 4'h1;
    if (still == 4'h4) o_flag[hi] <= ~o_flag[hi];
  end
endmodule // gbp_periph_model

// ---- verif/gbp_port_io_tb.sv ----
// Self-checking bench for the grouped byte port block
`timescale 1ns/1ps
`include "gbp_defs.vh"
module gbp_port_io_tb;
  localparam [95:0] PAT = 96'h5a3c_0f96_a5c3_f069_1234_8e71;
  reg         i_sys_clk = 1'b0;
  reg         i_rst_n   = 1'b0;
  reg         hsel      = 1'b0;
  reg         hwrite    = 1'b0;
  reg  [11:0] haddr     = 12'h000;
  reg  [1:0]  htrans    = 2'b00;
  reg  [31:0] hwdata    = 32'h0000_0000;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire [95:0] pout, poe, drive, pin;
  wire [11:0] ctl, flag;
  wire [7:0]  rises;
  reg  [31:0] q;
  integer     failures = 0;
  integer     checked  = 0;
  integer     i;
  always #2.5 i_sys_clk = ~i_sys_clk;
  // Pin level: the block where it drives, the peripheral elsewhere
  assign pin = (poe & pout) | (~poe & drive);
  gbp_port_io i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(), .i_port_data_line(pin), .o_port_data_line(pout), .o_port_data_oe(poe),
    .o_control_strobe_line(ctl), .i_peripheral_flag_line(flag));
  gbp_periph_model #(.PAT(PAT)) i_peri (.i_sys_clk(i_sys_clk), .i_ctl(ctl),
    .o_flag(flag), .o_drive(drive), .o_rises(rises));
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [95:0] got, input [95:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One single AHB-Lite transfer; waits on ready in both phases
  task ahb(input [11:0] a, input w, input [31:0] d, output [31:0] r);
    integer n;
    begin
      n = 0;
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      @(posedge i_sys_clk);
      while (hreadyout !== 1'b1 && n < 64) begin @(posedge i_sys_clk); n = n + 1; end
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      @(posedge i_sys_clk);
      while (hreadyout !== 1'b1 && n < 64) begin @(posedge i_sys_clk); n = n + 1; end
      r = hrdata;
      if (n >= 64) chk(1'b0, 1'b1);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    reg [31:0] r;
    begin ahb(a, 1'b1, d, r); end
  endtask
  task rd(input [11:0] a, output [31:0] r);
    begin ahb(a, 1'b0, 32'h0000_0000, r); end
  endtask
  // Start a command and wait for busy to drop
  task op(input r, input b, input v, input [2:0] w, input [3:0] p, input [6:0] k);
    integer n;
    begin
      wr(`GBP_OFF_CMD, {9'h000, k, 4'h0, p, 1'b0, w, v, b, r, 1'b1});
      q = 32'h0000_0001;
      for (n = 0; n < 500 && q[`GBP_ST_BUSY] !== 1'b0; n = n + 1) rd(`GBP_OFF_STATUS, q);
      if (q[`GBP_ST_BUSY] !== 1'b0) chk(1'b0, 1'b1);
    end
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    wr(`GBP_OFF_HSCFG, 32'h0002_0002);
    op(1, 0, 0, `GBP_W_WORD, 10, 0);
    wr(`GBP_OFF_HSCFG, 32'h0000_0000);
    op(1, 0, 0, `GBP_W_OCT, 0, 0);
    rd(`GBP_OFF_RDATA0, q); chk(q, {16'h0000, PAT[95:80]});
    rd(`GBP_OFF_RDATA2, q);
    rd(`GBP_OFF_RDATA0, q); chk(q, PAT[31:0]);
    rd(`GBP_OFF_RDATA1, q); chk(q, PAT[63:32]);
    rd(`GBP_OFF_RDATA2, q); rd(`GBP_OFF_STATUS, q); chk(q[`GBP_ST_RDV], 1'b0);
    for (i = 0; i < 5; i = i + 1) op(0, 0, 0, i, 0, 0);
    chk(q[`GBP_ST_ERR], 1'b0);
    wr(`GBP_OFF_WDATA0, 32'hffff_ffff);
    op(0, 0, 0, `GBP_W_WORD, 3, 0); chk(q[`GBP_ST_ERR], 1'b1);
    op(0, 0, 0, `GBP_W_QUAD, 2, 0); chk(q[`GBP_ST_ERR], 1'b1);
    op(0, 0, 0, `GBP_W_ALL, 4, 0); chk(pout, 96'h0);
    wr(`GBP_OFF_WDATA0, 32'haa00_0000);
    op(0, 0, 0, `GBP_W_BYTE, 3, 0); chk(pout[31:0], 32'haa00_0000);
    chk(poe[31:24], 8'hff);
    wr(`GBP_OFF_POLARITY, 32'h0000_0008); repeat (3) @(posedge i_sys_clk);
    chk(pout[31:24], 8'h55);
    wr(`GBP_OFF_POLARITY, 32'h0000_0000);
    op(0, 1, 1, `GBP_W_BYTE, 6, 2); chk(pout[55:48], 8'h04);
    op(0, 1, 1, `GBP_W_BYTE, 6, 8); chk(q[`GBP_ST_ERR], 1'b1);
    op(0, 1, 1, `GBP_W_ALL, 0, 95); chk(pout[95], 1'b1);
    wr(`GBP_OFF_HSCFG, 32'h0003_0001); wr(`GBP_OFF_WDATA2, 32'hc3a5_0f1e);
    i = rises;
    op(0, 0, 0, `GBP_W_QUAD, 8, 0); chk(pout[95:64], 32'hc3a5_0f1e);
    chk(rises - i[7:0], 8'h04);
    wr(`GBP_OFF_HSCFG, 32'h0001_0002); wr(`GBP_OFF_WDATA0, 32'h0000_5aa5);
    op(0, 0, 0, `GBP_W_WORD, 0, 0); chk(pout[15:0], 16'h5aa5);
    chk(ctl, 12'h000);
    close_out;
  end
  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #100000;
    failures = failures + 1;
    close_out;
  end
endmodule // gbp_port_io_tb
